// File: cpu_core.sv
// Purpose: 8-bit core: fetch, addressing, stack and interrupt entry.
// Assumes: prog_data shows the word at prog_addr in the same cycle.
// Notes: I/O other than status and stack pointer lives outside.
`timescale 1ns/1ns
module cpu_core #(
   parameter int PC_W = 12,
   parameter int SRAM_BYTES = 512,
   parameter int IRQ_N = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   output logic [PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   output logic [cpu_pkg::IO_SEL_W-1:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_we,
   output logic io_re,
   input wire logic [7:0] io_rdata,
   input wire logic [IRQ_N-1:0] irq_req,
   output logic [IRQ_N-1:0] irq_ack
);
   import cpu_pkg::*;

   localparam int SA_W = $clog2(SRAM_BYTES);

   state_type state;
   state_type next_state;
   logic [15:0] instr;
   logic instr_valid;
   logic next_valid;
   logic [PC_W-1:0] next_prog_addr;
   logic [8:0] stack_pointer;
   logic [8:0] next_sp;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [PC_W-1:0] ret_addr;
   logic [PC_W-1:0] jump_target;
   logic [4:0] hold_reg;
   logic byte_high;
   logic ret_int;
   logic [7:0] pop_high;
   logic [7:0] sram [SRAM_BYTES];
   logic [7:0] rd_a;
   logic [7:0] rd_b;
   logic [15:0] pointer_a;
   logic [15:0] pointer_b;
   logic [15:0] pointer_c;
   logic [IRQ_N-1:0] irq_pick;
   logic [PC_W-1:0] irq_vector;

   ////////////////////////////////////////////////////////////
   // Instruction decode.

   // Field extraction from the executing word.
   wire [4:0] dst = instr[8:4];
   wire [4:0] src_reg = {instr[9], instr[3:0]};
   wire [4:0] imm_dst = IMM_REG_BASE | {1'b0, instr[7:4]};
   wire [7:0] imm_k = {instr[11:8], instr[3:0]};
   wire [5:0] top6 = instr[15:10];
   wire [3:0] top4 = instr[15:12];
   wire [3:0] mode = instr[3:0];
   wire [5:0] disp = {instr[13], instr[11:10], instr[2:0]};
   wire [5:0] io_field = {instr[10:9], instr[3:0]};

   // Instruction classes.
   wire is_rr = top6 inside {OP_SUB_CARRY, OP_ADD, OP_COMPARE, OP_SUB,
      OP_ADD_CARRY, OP_AND, OP_EOR, OP_OR, OP_MOVE};
   wire is_imm = top4 inside {OP_IMM_COMPARE, OP_IMM_SUB_CARRY,
      OP_IMM_SUBTRACT, OP_IMM_OR, OP_IMM_AND, OP_IMM_LOAD};
   wire is_ldst = top6 == OP_LOAD_STORE;
   wire is_disp = instr[15:14] == 2'b10 && !instr[12];
   wire is_io = top4 == OP_IO;
   wire is_direct = is_ldst && mode == MODE_DIRECT;
   wire is_relative_jump = top4 == OP_REL_JUMP;
   wire is_relative_call = top4 == OP_REL_CALL;
   wire is_indirect_jump = instr == OP_IND_JUMP;
   wire is_indirect_call = instr == OP_IND_CALL;
   wire is_const = instr == OP_CONST_LOAD;
   wire is_ret = instr == OP_RETURN;
   wire is_reti = instr == OP_RETURN_INT;

   // Indirect mode selection.
   wire ind_a = mode inside {MODE_A, MODE_A_INC, MODE_A_DEC};
   wire ind_b = mode inside {MODE_B_INC, MODE_B_DEC};
   wire ind_c = mode inside {MODE_C_INC, MODE_C_DEC};
   wire pre_dec = mode inside {MODE_A_DEC, MODE_B_DEC, MODE_C_DEC};
   wire post_inc = mode inside {MODE_A_INC, MODE_B_INC, MODE_C_INC};
   wire is_ind = is_ldst && (ind_a || ind_b || ind_c);
   wire is_data = is_direct || is_ind || is_disp;
   wire store = is_io ? instr[11] : instr[9];

   // Pointer chosen by the addressing mode.
   wire [1:0] ptr_sel = is_disp ? (instr[3] ? PAIR_B : PAIR_C)
      : ind_a ? PAIR_A : ind_b ? PAIR_B : PAIR_C;
   wire [15:0] ptr_now = ptr_sel == PAIR_A ? pointer_a
      : ptr_sel == PAIR_B ? pointer_b : pointer_c;
   wire [15:0] ptr_dec = ptr_now - 16'h0001;
   wire [15:0] ptr_inc = ptr_now + 16'h0001;
   // Operand address for the indirect forms.
   wire [15:0] ind_addr = is_disp ? ptr_now + {10'h000, disp}
      : pre_dec ? ptr_dec
      : ptr_now;

   ////////////////////////////////////////////////////////////
   // Interrupt choice and execute qualifiers.

   // The lowest numbered pending request is taken.
   always_comb begin
      irq_pick = '0;
      irq_vector = '0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_pick = '0;
            irq_pick[i] = 1'b1;
            irq_vector = PC_W'(i + 1);
         end
      end
   end

   // Interrupts are taken only between whole instructions.
   wire take_irq = state == ST_RUN && instr_valid
      && status[7] && |irq_req;
   wire run_go = state == ST_RUN && instr_valid && !take_irq;
   wire go_call = run_go && (is_relative_call || is_indirect_call);
   wire go_ret = run_go && (is_ret || is_reti);
   wire go_const = run_go && is_const;
   wire go_jump = run_go && (is_relative_jump || is_indirect_jump);
   wire skip_word = run_go && is_direct;
   wire data_op = run_go && (is_data || is_io);
   wire push_lo = take_irq || go_call;
   wire pushing = push_lo || state == ST_PUSH_HI;
   wire popping = state == ST_POP_HI || state == ST_POP_LO;

   // Flow targets and the return address.
   wire [PC_W-1:0] rel_target = prog_addr + PC_W'(instr[11:0]);
   wire [PC_W-1:0] call_ret = take_irq ? prog_addr - PC_W'(1) : prog_addr;
   wire [15:0] ret16 = {{(16 - PC_W){1'b0}}, ret_addr};
   wire [15:0] call16 = {{(16 - PC_W){1'b0}}, call_ret};
   wire [8:0] sp_plus = stack_pointer + 9'h001;
   wire [8:0] sp_minus = stack_pointer - 9'h001;

   ////////////////////////////////////////////////////////////
   // Data space access and decode.

   // One data access per cycle: stack, I/O or operand.
   wire [15:0] mem_addr = pushing ? {7'h00, stack_pointer}
      : popping ? {7'h00, sp_plus}
      : is_io ? IO_BASE + {10'h000, io_field}
      : is_direct ? prog_data
      : ind_addr;
   wire mem_we = pushing || (data_op && store);
   wire mem_rd = data_op && !store;
   wire [7:0] mem_wdata = push_lo ? call16[7:0]
      : state == ST_PUSH_HI ? ret16[15:8] : rd_a;

   // Address map: registers, I/O window, then SRAM.
   wire at_reg = mem_addr < 16'(REG_COUNT);
   wire at_io = !at_reg && mem_addr < SRAM_BASE;
   wire [15:0] sram_off = mem_addr - SRAM_BASE;
   wire at_sram = !at_reg && !at_io
      && sram_off < 16'(SRAM_BYTES);
   wire [5:0] io_idx = mem_addr[5:0] - IO_BASE[5:0];
   wire io_int = at_io
      && io_idx inside {IO_SREG, IO_STACK_HI, IO_STACK_LO};
   wire [7:0] io_int_data = io_idx == IO_SREG ? status
      : io_idx == IO_STACK_HI ? {7'h00, stack_pointer[8]}
      : stack_pointer[7:0];
   wire [7:0] sram_rdata = at_sram ? sram[sram_off[SA_W-1:0]] : 8'h00;
   wire [7:0] mem_rdata = at_reg ? rd_b
      : io_int ? io_int_data : sram_rdata;
   wire ext_io_rd = mem_rd && at_io && !io_int;
   wire ext_io_wr = mem_we && at_io && !io_int;
   wire sreg_wr = mem_we && io_int && io_idx == IO_SREG;
   wire sph_wr = mem_we && io_int && io_idx == IO_STACK_HI;
   wire spl_wr = mem_we && io_int && io_idx == IO_STACK_LO;

   ////////////////////////////////////////////////////////////
   // ALU.

   // Second operand is a register or the immediate constant.
   wire [7:0] opb = is_imm ? imm_k : rd_b;
   wire use_c = is_imm ? top4 == OP_IMM_SUB_CARRY
      : top6 inside {OP_ADD_CARRY, OP_SUB_CARRY};
   wire op_add = !is_imm && top6 inside {OP_ADD, OP_ADD_CARRY};
   wire op_sub = is_imm ? top4 inside {OP_IMM_COMPARE, OP_IMM_SUB_CARRY,
      OP_IMM_SUBTRACT} : top6 inside {OP_SUB, OP_SUB_CARRY, OP_COMPARE};
   wire op_and = is_imm ? top4 == OP_IMM_AND : top6 == OP_AND;
   wire op_or = is_imm ? top4 == OP_IMM_OR : top6 == OP_OR;
   wire op_eor = !is_imm && top6 == OP_EOR;
   wire no_write = is_imm ? top4 == OP_IMM_COMPARE : top6 == OP_COMPARE;
   wire flags_on = op_add || op_sub || op_and || op_or || op_eor;
   wire cin = use_c && status[FLAG_C];
   wire [8:0] sum = {1'b0, rd_a} + {1'b0, opb} + {8'h00, cin};
   wire [8:0] diff = {1'b0, rd_a} - {1'b0, opb} - {8'h00, cin};
   wire [7:0] alu_res = op_add ? sum[7:0] : op_sub ? diff[7:0]
      : op_and ? rd_a & opb : op_or ? rd_a | opb
      : op_eor ? rd_a ^ opb : opb;
   wire c_new = op_add ? sum[8] : op_sub ? diff[8] : status[FLAG_C];
   // A carried subtract keeps zero only if it was already zero.
   wire z_new = alu_res == 8'h00 && (!(use_c && op_sub) || status[FLAG_Z]);
   wire [7:0] alu_flags = {status[7:3], alu_res[7], z_new, c_new};

   // Register file write selection.
   wire load_ok = mem_rd && !ext_io_rd;
   wire store_reg = data_op && store && at_reg;
   wire alu_wr = run_go && (is_rr || is_imm) && !no_write;
   wire [7:0] const_byte = byte_high ? prog_data[15:8]
      : prog_data[7:0];
   wire wr_en = alu_wr || load_ok || store_reg
      || state == ST_IO_WAIT || state == ST_CONST;
   wire [4:0] wr_sel = state == ST_IO_WAIT ? hold_reg
      : state == ST_CONST ? CONST_DST
      : store_reg ? mem_addr[4:0]
      : is_imm ? imm_dst : dst;
   wire [7:0] wr_data = state == ST_IO_WAIT ? io_rdata
      : state == ST_CONST ? const_byte
      : store_reg ? rd_a : load_ok ? mem_rdata : alu_res;
   wire [4:0] rd_a_sel = is_imm ? imm_dst : dst;
   wire [4:0] rd_b_sel = (is_rr && !data_op && !popping) ? src_reg
      : mem_addr[4:0];
   wire ptr_we = run_go && is_ind
      && (pre_dec || post_inc);
   wire [15:0] ptr_data = pre_dec ? ptr_dec : ptr_inc;

   cpu_regfile #(
      .COUNT(REG_COUNT)
   ) u_regs (
      .clk(clk),
      .reset_n(reset_n),
      .rd_a_sel(rd_a_sel),
      .rd_a(rd_a),
      .rd_b_sel(rd_b_sel),
      .rd_b(rd_b),
      .wr_en(wr_en),
      .wr_sel(wr_sel),
      .wr_data(wr_data),
      .ptr_we(ptr_we),
      .ptr_sel(ptr_sel),
      .ptr_data(ptr_data),
      .pointer_a(pointer_a),
      .pointer_b(pointer_b),
      .pointer_c(pointer_c)
   );

   ////////////////////////////////////////////////////////////
   // Sequencing.

   // Multi-cycle work leaves the run state for one cycle each, two for a return.
   assign next_state = push_lo ? ST_PUSH_HI
      : go_ret ? ST_POP_HI
      : go_const ? ST_CONST
      : ext_io_rd ? ST_IO_WAIT
      : state == ST_POP_HI ? ST_POP_LO : ST_RUN;

   // Fetch address: normally the word after the one in flight.
   assign next_prog_addr = state == ST_PUSH_HI ? jump_target
      : state == ST_POP_LO ? PC_W'({pop_high, mem_rdata})
      : state == ST_CONST ? ret_addr
      : (state != ST_RUN || push_lo || go_ret) ? prog_addr
      : go_const ? pointer_c[PC_W:1]
      : go_jump && is_indirect_jump ? pointer_c[PC_W-1:0]
      : go_jump ? rel_target
      : prog_addr + PC_W'(1);

   // A jump or a skipped word empties the prefetch slot for one cycle.
   assign next_valid = state == ST_IO_WAIT ? instr_valid
      : state != ST_RUN ? 1'b0
      : !(go_jump || skip_word || push_lo
         || go_ret || go_const);

   // Fetch, state and flow bookkeeping.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_RUN;
         prog_addr <= '0;
         instr <= 16'h0000;
         instr_valid <= 1'b0;
      end else begin
         state <= next_state;
         prog_addr <= next_prog_addr;
         instr_valid <= next_valid;
         if (state == ST_RUN) begin
            instr <= prog_data;
         end
      end
   end

   // Values saved for the multi-cycle sequences.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ret_addr <= '0;
         jump_target <= '0;
         hold_reg <= 5'h00;
         byte_high <= 1'b0;
         ret_int <= 1'b0;
      end else if (state == ST_RUN) begin
         ret_addr <= call_ret;
         jump_target <= take_irq ? irq_vector
            : is_indirect_call ? pointer_c[PC_W-1:0] : rel_target;
         hold_reg <= dst;
         byte_high <= pointer_c[0];
         ret_int <= is_reti;
      end
   end

   // Stack pointer: software write, push or pop.
   assign next_sp = sph_wr ? {mem_wdata[0], stack_pointer[7:0]}
      : spl_wr ? {stack_pointer[8], mem_wdata}
      : pushing ? sp_minus
      : popping ? sp_plus : stack_pointer;

   // Status: software write, interrupt entry, return, flags.
   assign next_status = sreg_wr ? mem_wdata
      : take_irq ? status & ~I_MASK
      : (state == ST_POP_LO && ret_int) ? status | I_MASK
      : (run_go && flags_on) ? alu_flags : status;

   // The stack pointer starts at a fixed value until software sets it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stack_pointer <= STACK_RESET;
         status <= STATUS_RESET;
         pop_high <= 8'h00;
      end else begin
         stack_pointer <= next_sp;
         status <= next_status;
         if (state == ST_POP_HI) begin
            pop_high <= mem_rdata;
         end
      end
   end

   // Internal SRAM write port.
   always_ff @(posedge clk) begin
      if (mem_we && at_sram) begin
         sram[sram_off[SA_W-1:0]] <= mem_wdata;
      end
   end

   // External I/O strobes go out one cycle after the access.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_addr <= 6'h00;
         io_wdata <= 8'h00;
         io_we <= 1'b0;
         io_re <= 1'b0;
         irq_ack <= '0;
      end else begin
         io_addr <= io_idx;
         io_wdata <= mem_wdata;
         io_we <= ext_io_wr;
         io_re <= ext_io_rd;
         irq_ack <= take_irq ? irq_pick : '0;
      end
   end
endmodule

// File: cpu_core_props.sv
// Purpose: Port assertions for the core.
// Assumes: One clock, reset_n active low.
// Notes: Watches I/O strobes and interrupt entry.
`timescale 1ns/1ns
module cpu_core_props #(
   parameter int PC_W = 12,
   parameter int SRAM_BYTES = 512,
   parameter int IRQ_N = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   input wire logic [cpu_pkg::IO_SEL_W-1:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic [7:0] io_rdata,
   input wire logic [IRQ_N-1:0] irq_req,
   input wire logic [IRQ_N-1:0] irq_ack
);
   import cpu_pkg::*;
   logic [PC_W-1:0] vec;
   logic take;
   // Vector address of the acknowledged line.
   always_comb begin
      vec = '0;
      for (int i = 0; i < IRQ_N; i++) begin
         if (irq_ack[i]) begin
            vec = PC_W'(i + 1);
         end
      end
   end
   assign take = |irq_ack;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // A read holds the fetch for one cycle and is not repeated at once.
   sequence s_read_stall;
      !io_re && $stable(prog_addr);
   endsequence
   ////////////////////////////////////////////////////////////////////
   AST_ACK_ONEHOT: assert property ($onehot0(irq_ack))
      else $error("irq_ack has several bits set");
   AST_ACK_REQUESTED: assert property (
      take |-> ($past(irq_req) & irq_ack) != '0)
      else $error("irq_ack for a line that was not requesting");
   AST_ACK_LOWEST: assert property (
      take |-> ($past(irq_req) & (irq_ack - 1'b1)) == '0)
      else $error("irq_ack skipped a lower pending line");
   // The vector is fetched on the edge that ends the acknowledge cycle.
   AST_ACK_VECTOR: assert property (
      take |=> prog_addr == $past(vec))
      else $error("interrupt entry fetched the wrong vector");
   AST_ACK_NO_IO: assert property (take |-> !io_we && !io_re)
      else $error("I/O strobe beside interrupt entry");
   AST_IO_SINGLE: assert property (io_we |-> !io_re)
      else $error("read and write strobes together");
   AST_IO_EXTERNAL: assert property (
      (io_we || io_re) |-> io_addr < IO_STACK_LO)
      else $error("internal I/O location shown on the external bus");
   AST_READ_STALL: assert property (io_re |=> s_read_stall)
      else $error("read did not stall the fetch for one cycle");
endmodule

// File: cpu_pkg.sv
// Purpose: Shared constants for the 8-bit core and its register file.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Instruction codes are fixed here and used by the core decoder.
package cpu_pkg;
   localparam int REG_SEL_W = 5;
   localparam int IO_SEL_W = 6;
   localparam int REG_COUNT = 32;
   localparam int IO_COUNT = 64;
   localparam logic [15:0] IO_BASE = 16'h0020;
   localparam logic [15:0] SRAM_BASE = 16'h0060;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [4:0] PTR_BASE = 5'h1A;
   localparam logic [4:0] IMM_REG_BASE = 5'h10;
   localparam logic [4:0] CONST_DST = 5'h00;
   localparam logic [1:0] PAIR_A = 2'h0;
   localparam logic [1:0] PAIR_B = 2'h1;
   localparam logic [1:0] PAIR_C = 2'h2;
   localparam logic [5:0] IO_SREG = 6'h3F;
   localparam logic [5:0] IO_STACK_HI = 6'h3E;
   localparam logic [5:0] IO_STACK_LO = 6'h3D;
   localparam logic [8:0] STACK_RESET = 9'h000;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] I_MASK = 8'h80;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;
   localparam logic [5:0] OP_SUB_CARRY = 6'h02;
   localparam logic [5:0] OP_ADD = 6'h03;
   localparam logic [5:0] OP_COMPARE = 6'h05;
   localparam logic [5:0] OP_SUB = 6'h06;
   localparam logic [5:0] OP_ADD_CARRY = 6'h07;
   localparam logic [5:0] OP_AND = 6'h08;
   localparam logic [5:0] OP_EOR = 6'h09;
   localparam logic [5:0] OP_OR = 6'h0A;
   localparam logic [5:0] OP_MOVE = 6'h0B;
   localparam logic [5:0] OP_LOAD_STORE = 6'h24;
   localparam logic [3:0] OP_IMM_COMPARE = 4'h3;
   localparam logic [3:0] OP_IMM_SUB_CARRY = 4'h4;
   localparam logic [3:0] OP_IMM_SUBTRACT = 4'h5;
   localparam logic [3:0] OP_IMM_OR = 4'h6;
   localparam logic [3:0] OP_IMM_AND = 4'h7;
   localparam logic [3:0] OP_IO = 4'hB;
   localparam logic [3:0] OP_REL_JUMP = 4'hC;
   localparam logic [3:0] OP_REL_CALL = 4'hD;
   localparam logic [3:0] OP_IMM_LOAD = 4'hE;
   localparam logic [15:0] OP_CONST_LOAD = 16'h95C8;
   localparam logic [15:0] OP_IND_JUMP = 16'h9409;
   localparam logic [15:0] OP_IND_CALL = 16'h9509;
   localparam logic [15:0] OP_RETURN = 16'h9508;
   localparam logic [15:0] OP_RETURN_INT = 16'h9518;
   localparam logic [3:0] MODE_DIRECT = 4'h0;
   localparam logic [3:0] MODE_C_INC = 4'h1;
   localparam logic [3:0] MODE_C_DEC = 4'h2;
   localparam logic [3:0] MODE_B_INC = 4'h9;
   localparam logic [3:0] MODE_B_DEC = 4'hA;
   localparam logic [3:0] MODE_A = 4'hC;
   localparam logic [3:0] MODE_A_INC = 4'hD;
   localparam logic [3:0] MODE_A_DEC = 4'hE;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_IO_WAIT = 3'b001,
      ST_CONST = 3'b010,
      ST_PUSH_HI = 3'b011,
      ST_POP_HI = 3'b100,
      ST_POP_LO = 3'b101
   } state_type;
endpackage

// File: cpu_regfile.sv
// Purpose: Working register file with pointer pair write port.
// Assumes: Reads are combinational, writes on the clock edge.
// Notes: A byte write beats a pointer write to the same register.
`timescale 1ns/1ns
module cpu_regfile #(
   parameter int COUNT = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [cpu_pkg::REG_SEL_W-1:0] rd_a_sel,
   output logic [7:0] rd_a,
   input wire logic [cpu_pkg::REG_SEL_W-1:0] rd_b_sel,
   output logic [7:0] rd_b,
   input wire logic wr_en,
   input wire logic [cpu_pkg::REG_SEL_W-1:0] wr_sel,
   input wire logic [7:0] wr_data,
   input wire logic ptr_we,
   input wire logic [1:0] ptr_sel,
   input wire logic [15:0] ptr_data,
   output logic [15:0] pointer_a,
   output logic [15:0] pointer_b,
   output logic [15:0] pointer_c
);
   import cpu_pkg::*;

   logic [7:0] regs [COUNT];
   logic [4:0] ptr_lo;
   logic [4:0] ptr_hi;

   // Two read ports feed the ALU in the same cycle.
   assign rd_a = regs[rd_a_sel];
   assign rd_b = regs[rd_b_sel];
   // Pairs start at the first pointer register, low byte first.
   assign ptr_lo = PTR_BASE + {2'b00, ptr_sel, 1'b0};
   assign ptr_hi = ptr_lo + 5'h01;
   assign pointer_a = {regs[PTR_BASE + 5'h01], regs[PTR_BASE]};
   assign pointer_b = {regs[PTR_BASE + 5'h03], regs[PTR_BASE + 5'h02]};
   assign pointer_c = {regs[PTR_BASE + 5'h05], regs[PTR_BASE + 5'h04]};

   // Result and pointer updates land on the same edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < COUNT; i++) begin
            regs[i] <= REG_RESET;
         end
      end else begin
         if (ptr_we) begin
            regs[ptr_lo] <= ptr_data[7:0];
            regs[ptr_hi] <= ptr_data[15:8];
         end
         if (wr_en) begin
            regs[wr_sel] <= wr_data;
         end
      end
   end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench running a small program.
// Assumes: Program memory answers in the same cycle.
// Notes: Expected I/O writes are queued as the program is built.
`timescale 1ns/1ns
module tb_top;
   import cpu_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [11:0] prog_addr;
   logic [15:0] prog_data;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata, irq_req, irq_ack, exp_ack;
   logic io_we, io_re;
   logic [15:0] rom [0:255];
   logic [7:0] rf [0:31];
   logic [13:0] exp_q [$];
   logic [13:0] w;
   int err_count = 0;
   int n_compared = 0;
   int seed = 30001;
   int pc, acks;
   always #10 clk = ~clk;
   assign prog_data = rom[prog_addr[7:0]];
   cpu_core #(.PC_W(12), .SRAM_BYTES(512), .IRQ_N(8)) dut (
      .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
      .irq_req(irq_req), .irq_ack(irq_ack));
   ////////////////////////////////////////////////////////////////////
   // Compare, program building and closing tasks.
   task automatic check(string what, logic [15:0] seen, logic [15:0] ex);
      n_compared++;
      if (seen !== ex) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, ex, seen);
      end
   endtask
   task automatic emit(logic [15:0] word);
      rom[pc] = word;
      pc++;
   endtask
   task automatic imm_load(logic [4:0] d, logic [7:0] k);
      emit({4'hE, k[7:4], d[3:0], k[3:0]});
      rf[d] = k;
   endtask
   task automatic out(logic [5:0] a, logic [4:0] r, bit keep);
      emit({4'hB, 1'b1, a[5:4], r, a[3:0]});
      if (keep) exp_q.push_back({a, rf[r]});
   endtask
   task automatic mem(logic s, logic [4:0] d, logic [3:0] mode);
      emit({6'h24, s, d, mode});
   endtask
   task automatic ptr(logic [4:0] lo, logic [15:0] v);
      imm_load(lo, v[7:0]);
      imm_load(lo + 5'h01, v[15:8]);
   endtask
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Each write is matched with the oldest note, each acknowledge with exp_ack.
   always @(posedge clk) begin
      if (reset_n && io_we) begin
         w = exp_q.size() > 0 ? exp_q.pop_front() : 14'h3FFF;
         check("io write", 16'({io_addr, io_wdata}), 16'(w));
      end
      if (reset_n && irq_ack !== 8'h00) begin
         acks++;
         check("irq_ack", 16'(irq_ack), 16'(exp_ack));
      end
   end
   // Builds the program, then runs it to the end.
   initial begin
      logic [7:0] rdval;
      logic [7:0] req;
      int v;
      rdval = 8'($random(seed));
      req = 8'($random(seed)) | 8'h80;
      exp_ack = req & (~req + 8'h01);
      irq_req = 8'h00;
      io_rdata = 8'h00;
      acks = 0;
      foreach (rom[i]) rom[i] = 16'h0000;
      foreach (rf[i]) rf[i] = 8'h00;
      for (int i = 7; i >= 0; i--) if (req[i]) v = i + 1;
      pc = 0;
      emit(16'hC00F);
      pc = 16;
      for (int d = 16; d < 32; d++) imm_load(5'(d), 8'($random(seed)));
      for (int d = 16; d < 32; d++) out(6'(d - 16), 5'(d), 1);
      ptr(5'h1A, 16'h0060);
      mem(1'b1, 5'h10, 4'hD);
      mem(1'b1, 5'h11, 4'hD);
      mem(1'b0, 5'h12, 4'hE);
      mem(1'b0, 5'h13, 4'hE);
      rf[18] = rf[17];
      rf[19] = rf[16];
      ptr(5'h1A, 16'h0011);
      mem(1'b0, 5'h14, 4'hC);
      rf[20] = rf[17];
      ptr(5'h1C, 16'h0022);
      emit(16'hAD5F);
      rf[21] = rf[17];
      ptr(5'h1A, 16'h0025);
      mem(1'b1, 5'h10, 4'hC);
      exp_q.push_back({6'h05, rf[16]});
      // Two-word store: the address word must be skipped, not executed.
      mem(1'b1, 5'h11, 4'h0);
      emit(16'h0027);
      exp_q.push_back({6'h07, rf[17]});
      for (int d = 18; d < 22; d++) out(6'(d), 5'(d), 1);
      rom[200] = 16'($random(seed));
      for (int b = 0; b < 2; b++) begin
         ptr(5'h1E, 16'(400 + b));
         emit(OP_CONST_LOAD);
         rf[0] = b ? rom[200][15:8] : rom[200][7:0];
         out(6'(24 + b), 5'h00, 1);
      end
      emit({4'hB, 1'b0, 2'h1, 5'h16, 4'h6});
      rf[22] = rdval;
      out(6'h1A, 5'h16, 1);
      emit(16'hC001);
      out(6'h3A, 5'h10, 0);
      out(6'h1B, 5'h10, 1);
      ptr(5'h1E, 16'(pc + 4));
      emit(OP_IND_JUMP);
      out(6'h3A, 5'h10, 0);
      out(6'h1C, 5'h11, 1);
      imm_load(5'h10, 8'hFF);
      out(IO_STACK_LO, 5'h10, 0);
      imm_load(5'h10, 8'h01);
      out(IO_STACK_HI, 5'h10, 0);
      imm_load(5'h10, I_MASK);
      out(IO_SREG, 5'h10, 0);
      emit(16'hCFFF);
      pc = 1;
      for (int i = 1; i < 9; i++) out(6'(32 + i), 5'h10, i >= v);
      emit(16'hCFFF);
      @(posedge clk);
      irq_req <= req;
      io_rdata <= rdval;
      repeat (15) @(posedge clk);
      reset_n <= 1'b1;
      for (int t = 0; t < 3000 && (exp_q.size() > 0 || acks == 0); t++) begin
         @(posedge clk);
      end
      repeat (20) @(posedge clk);
      if (exp_q.size() > 0 || acks != 1) begin
         err_count++;
         $display("[FAIL] run expected all writes seen %0d left", exp_q.size());
      end
      $display("Program test ended");
      stop_test();
   end
endmodule
bind cpu_core cpu_core_props #(.PC_W(PC_W), .SRAM_BYTES(SRAM_BYTES),
   .IRQ_N(IRQ_N)) props (.clk(clk), .reset_n(reset_n),
   .prog_addr(prog_addr), .prog_data(prog_data), .io_addr(io_addr),
   .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
   .io_rdata(io_rdata), .irq_req(irq_req), .irq_ack(irq_ack));
